/* File: core/cca_defines.vh */
// Constants for the four-channel compare/capture array.
// Assumes a single 40 MHz clock and a timebase kept outside the array.
//
// Summary of operation
// - Capture code 010 triggers on rising pin
// - Capture code 011 triggers on either edge
// - Codes 100/101 capture on timer 0/1 overflow
// - Codes 110/111 capture on comparator A/B events
// - Compare code 000 only sets the flag
// - Compare code 001 sets output on match
// - Compare code 010 clears output on match
// - Compare code 011 toggles output on match
// - Codes 100/101 select inverting/non-inverting PWM
// - PWM alignment follows the timebase count mode
// - Control access reaches only the selected channel
// - Compare mode bit; match on all 16 bits
// - Compare event sets flag, optionally clears timebase
// - Output action happens whatever the interrupt enables
// - Reset sets every compare output to 1
// - DAC on: channels C, D keep pins undriven
// - External memory on: no channel drives pins
// - Normal mode period set by timebase TOP
// - Capture 000 disabled, 001 falling edge
// - Capture copies timebase, sets flag, optional clear
// - Pins sampled each cycle; two-cycle level recognised
// - Interrupt needs both enables; software clears flag
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH

// *************************************************
// Control register field positions
// *************************************************
`define CCA_CTRL_IEN     7
`define CCA_CTRL_DIR     6
`define CCA_CTRL_RSVD    5
`define CCA_CTRL_CTC     4
`define CCA_CTRL_CMP     3
`define CCA_CTRL_ACT_HI  2
`define CCA_CTRL_ACT_LO  0

// *************************************************
// Reset values
// *************************************************
`define CCA_CTRL_RESET   8'h00
`define CCA_DATA_RESET   16'h0000
`define CCA_SEL_RESET    2'h0
`define CCA_FLAG_RESET   4'h0
`define CCA_PIN_RESET    1'b1
`define CCA_TB_ZERO      16'h0000

// *************************************************
// Action codes
// *************************************************
`define CCA_ACT_OFF      3'h0
`define CCA_ACT_FALL     3'h1
`define CCA_ACT_RISE     3'h2
`define CCA_ACT_BOTH     3'h3
`define CCA_ACT_T0       3'h4
`define CCA_ACT_T1       3'h5
`define CCA_ACT_CMPA     3'h6
`define CCA_ACT_CMPB     3'h7
`define CCA_ACT_SET      3'h1
`define CCA_ACT_CLR      3'h2
`define CCA_ACT_TGL      3'h3
`define CCA_ACT_PWM_INV  3'h4
`define CCA_ACT_PWM_NON  3'h5

// *************************************************
// Timing
// *************************************************
`define CCA_PIN_HOLD_CYC 2

`endif

/* File: core/cca_pin_filter.v */
// Capture pin sampler with a two-sample stability filter.
// Assumes the pin is already synchronous to mclk.
`timescale 1ns/1ps
`include "cca_defines.vh"

module cca_pin_filter
(
    mclk,
    rst_n,
    pin,
    rise,
    fall
);
    input  wire mclk;  // System clock
    input  wire rst_n; // Asynchronous reset, active low
    input  wire pin;   // Raw capture pin
    output wire rise;  // One-cycle pulse on accepted rising level
    output wire fall;  // One-cycle pulse on accepted falling level

    reg sample; // Previous cycle's pin level
    reg stable; // Last level accepted as valid
    reg prev;   // Accepted level one cycle ago
    reg primed; // First level accepted since reset

    // ************************************************
    // Sampling and acceptance
    // ************************************************
    // A level is accepted once seen on two consecutive samples, so a
    // one-cycle glitch is ignored; the trade is one cycle of latency.
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            sample <= pin;
            if (pin == sample)
            begin
                stable <= pin;
            end
            primed <= primed | (pin == sample);
            prev   <= primed ? stable : pin; // No edge at reset
        end
    end

    assign rise = primed & stable & ~prev;
    assign fall = primed & ~stable & prev;

endmodule // cca_pin_filter

/* File: core/cca_trigger_sel.v */
// Capture trigger selector for one channel.
// Assumes all event inputs are one-cycle pulses on mclk.
`timescale 1ns/1ps
`include "cca_defines.vh"

module cca_trigger_sel
(
    action,
    pin_ok,
    rise,
    fall,
    t0_ovf,
    t1_ovf,
    cmp_a,
    cmp_b,
    trigger
);
    input  wire [2:0] action;  // Channel action code
    input  wire       pin_ok;  // Pin free for channel use
    input  wire       rise;    // Filtered rising edge
    input  wire       fall;    // Filtered falling edge
    input  wire       t0_ovf;  // Timer 0 overflow pulse
    input  wire       t1_ovf;  // Timer 1 overflow pulse
    input  wire       cmp_a;   // Comparator A event pulse
    input  wire       cmp_b;   // Comparator B event pulse
    output reg        trigger; // Capture request

    // ************************************************
    // Source decode
    // ************************************************
    // Pin-based sources die when the pin is lent to the DAC or memory bus
    always @*
    begin
        case (action)
            `CCA_ACT_OFF:  trigger = 1'b0;
            `CCA_ACT_FALL: trigger = fall & pin_ok;
            `CCA_ACT_RISE: trigger = rise & pin_ok;
            `CCA_ACT_BOTH: trigger = (rise | fall) & pin_ok;
            `CCA_ACT_T0:   trigger = t0_ovf;
            `CCA_ACT_T1:   trigger = t1_ovf;
            `CCA_ACT_CMPA: trigger = cmp_a;
            `CCA_ACT_CMPB: trigger = cmp_b;
            default:       trigger = 1'b0;
        endcase
    end

endmodule // cca_trigger_sel

/* File: core/cca_top.v */
// Four-channel compare/capture array core.
// Assumes the 16-bit timebase, comparators and pin muxing live outside;
// all inputs are synchronous to mclk and events are one-cycle pulses.
`timescale 1ns/1ps
`include "cca_defines.vh"

module cca_top
#(
    parameter NCH = 4 // Number of channels
)
(
    mclk,
    rst_n,
    sel_wr,
    sel_wdata,
    ctrl_wr,
    ctrl_wdata,
    data_wr,
    data_wdata,
    flag_clr,
    flag_clr_mask,
    array_irq_enable,
    timebase_count,
    timebase_down,
    capture_reload_select,
    timebase_count_mode,
    timer0_ovf,
    timer1_ovf,
    comp_a_event,
    comp_b_event,
    channel_pin_in,
    dac_enable,
    ext_mem_enable,
    channel_select_reg,
    channel_control_reg,
    channel_data_reg,
    channel_flag_reg,
    irq,
    timebase_clear,
    channel_pin_out,
    channel_pin_oe
);
    // ************************************************
    // Ports
    // ************************************************
    input  wire            mclk;                  // System clock
    input  wire            rst_n;                 // Asynchronous reset, active low
    input  wire            sel_wr;                // Write channel select
    input  wire [1:0]      sel_wdata;             // New channel select
    input  wire            ctrl_wr;               // Write selected control
    input  wire [7:0]      ctrl_wdata;            // New control value
    input  wire            data_wr;               // Write selected data
    input  wire [15:0]     data_wdata;            // New data value
    input  wire            flag_clr;              // Clear flags strobe
    input  wire [NCH-1:0]  flag_clr_mask;         // Flags to clear
    input  wire            array_irq_enable;      // Array interrupt enable
    input  wire [15:0]     timebase_count;        // Shared timebase
    input  wire            timebase_down;         // Timebase counting down
    input  wire            capture_reload_select; // Timebase capture mode
    input  wire [1:0]      timebase_count_mode;   // Timebase count mode
    input  wire            timer0_ovf;            // Timer 0 overflow pulse
    input  wire            timer1_ovf;            // Timer 1 overflow pulse
    input  wire            comp_a_event;          // Comparator A event
    input  wire            comp_b_event;          // Comparator B event
    input  wire [NCH-1:0]  channel_pin_in;        // Capture pins
    input  wire            dac_enable;            // DAC owns pins C, D
    input  wire            ext_mem_enable;        // Memory bus owns pins
    output reg  [1:0]      channel_select_reg;    // Selected channel
    output reg  [7:0]      channel_control_reg;   // Selected control readback
    output reg  [15:0]     channel_data_reg;      // Selected data readback
    output reg  [NCH-1:0]  channel_flag_reg;      // Event flags
    output reg             irq;                   // Array interrupt
    output reg             timebase_clear;        // Clear timebase pulse
    output wire [NCH-1:0]  channel_pin_out;       // Compare pin levels
    output wire [NCH-1:0]  channel_pin_oe;        // Compare pin drive enables

    // ************************************************
    // Shared decode
    // ************************************************
    wire [8*NCH-1:0]  ctrl_flat;  // All control registers
    wire [16*NCH-1:0] data_flat;  // All data registers
    wire [NCH-1:0]    evt;        // Per-channel event this cycle
    wire [NCH-1:0]    ctc_evt;    // Events that clear the timebase
    wire [NCH-1:0]    ien;        // Channel interrupt enables
    wire [NCH-1:0]    next_flag;  // Flag next value

    // Dual-slope timebase: auto-reload with count mode 1x
    wire dual_slope = ~capture_reload_select & timebase_count_mode[1];
    // Edge-aligned PWM when the timebase count mode is 0x, whatever the reload select
    wire edge_align = ~timebase_count_mode[1];
    // Timebase at its bottom value
    wire tb_bottom  = (timebase_count == `CCA_TB_ZERO);
    // Bits kept by a control write: direction is read-only, bit 5 reserved
    wire [7:0] wr_keep = 8'h60;

    // ************************************************
    // Per-channel logic
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1)
        begin : g_ch
            reg  [7:0]  ctrl_q;  // Control register
            reg  [15:0] data_q;  // Compare value or captured count
            reg         pin_q;   // Compare output level
            reg         oe_q;    // Pin drive enable
            wire        rise;    // Filtered rising edge
            wire        fall;    // Filtered falling edge
            wire        trig;    // Capture request
            wire        pin_ok;  // Pin not lent elsewhere
            wire        cmp;     // Compare mode
            wire [2:0]  act;     // Action code
            wire        match;   // Compare match
            wire        sel_me;  // This channel is selected

            assign cmp    = ctrl_q[`CCA_CTRL_CMP];
            assign act    = ctrl_q[`CCA_CTRL_ACT_HI:`CCA_CTRL_ACT_LO];
            assign sel_me = (channel_select_reg == i);
            // Channels C and D give their pins to the DAC
            assign pin_ok = ~ext_mem_enable & ~(dac_enable & (i >= 2));
            // Full 16-bit equality; the period comes from the timebase TOP
            assign match  = cmp & (data_q == timebase_count);
            assign evt[i] = match | (~cmp & trig);
            assign ctc_evt[i] = evt[i] & ctrl_q[`CCA_CTRL_CTC];
            assign ien[i] = ctrl_q[`CCA_CTRL_IEN];
            assign ctrl_flat[8*i +: 8]   = ctrl_q;
            assign data_flat[16*i +: 16] = data_q;
            assign channel_pin_out[i]    = pin_q;
            assign channel_pin_oe[i]     = oe_q;

            // Two-sample filter on the capture pin
            cca_pin_filter u_filt
            (
                .mclk  (mclk),
                .rst_n (rst_n),
                .pin   (channel_pin_in[i]),
                .rise  (rise),
                .fall  (fall)
            );

            // Capture source selection
            cca_trigger_sel u_trig
            (
                .action  (act),
                .pin_ok  (pin_ok),
                .rise    (rise),
                .fall    (fall),
                .t0_ovf  (timer0_ovf),
                .t1_ovf  (timer1_ovf),
                .cmp_a   (comp_a_event),
                .cmp_b   (comp_b_event),
                .trigger (trig)
            );

            // Control register; only the selected channel takes a write
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ctrl_q <= `CCA_CTRL_RESET;
                end
                else
                begin
                    if (ctrl_wr && sel_me)
                    begin
                        // Direction and reserved bits ignore writes
                        ctrl_q <= (ctrl_wdata & ~wr_keep) | (ctrl_q & wr_keep);
                    end
                    if (evt[i] && dual_slope)
                    begin
                        // Count direction at the event, dual-slope only
                        ctrl_q[`CCA_CTRL_DIR] <= timebase_down;
                    end
                end
            end

            // Data register; a capture beats a same-cycle software write
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    data_q <= `CCA_DATA_RESET;
                end
                else if (~cmp && trig)
                begin
                    // No overrun guard: an unread capture is overwritten
                    data_q <= timebase_count;
                end
                else if (data_wr && sel_me)
                begin
                    data_q <= data_wdata;
                end
            end

            // Output action; runs on match whatever the interrupt enables
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pin_q <= `CCA_PIN_RESET;
                end
                else if (cmp)
                begin
                    case (act)
                        `CCA_ACT_OFF:
                        begin
                            pin_q <= pin_q;
                        end
                        `CCA_ACT_SET:
                        begin
                            if (match) pin_q <= 1'b1;
                        end
                        `CCA_ACT_CLR:
                        begin
                            if (match) pin_q <= 1'b0;
                        end
                        `CCA_ACT_TGL:
                        begin
                            if (match) pin_q <= ~pin_q;
                        end
                        `CCA_ACT_PWM_INV:
                        begin
                            // Match wins over bottom so a zero value pins it low
                            if (edge_align)
                            begin
                                if (match) pin_q <= 1'b0;
                                else if (tb_bottom) pin_q <= 1'b1;
                            end
                            else if (match)
                            begin
                                pin_q <= ~timebase_down;
                            end
                        end
                        `CCA_ACT_PWM_NON:
                        begin
                            if (edge_align)
                            begin
                                if (match) pin_q <= 1'b1;
                                else if (tb_bottom) pin_q <= 1'b0;
                            end
                            else if (match)
                            begin
                                pin_q <= timebase_down;
                            end
                        end
                        default:
                        begin
                            // Reserved codes hold the output
                            pin_q <= pin_q;
                        end
                    endcase
                end
            end

            // Drive enable: compare mode, real action, pin not lent away
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    oe_q <= 1'b0;
                end
                else
                begin
                    oe_q <= cmp & (act != `CCA_ACT_OFF) & ~(act[2] & act[1])
                            & pin_ok;
                end
            end
        end
    endgenerate

    // ************************************************
    // Flags: hardware set beats software clear
    // ************************************************
    assign next_flag = (channel_flag_reg & ~({NCH{flag_clr}} & flag_clr_mask)) | evt;

    // Flag register, interrupt and timebase clear
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_flag_reg <= `CCA_FLAG_RESET;
            irq              <= 1'b0;
            timebase_clear   <= 1'b0;
        end
        else
        begin
            channel_flag_reg <= next_flag;
            // Both enables needed; flags stay until software clears them
            irq <= array_irq_enable & (|(next_flag & ien));
            // Pulse asks the timebase to load zero
            timebase_clear <= |ctc_evt;
        end
    end

    // ************************************************
    // Channel select and readback
    // ************************************************
    // Readback is registered, so it lags a write or select by one cycle
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_select_reg  <= `CCA_SEL_RESET;
            channel_control_reg <= `CCA_CTRL_RESET;
            channel_data_reg    <= `CCA_DATA_RESET;
        end
        else
        begin
            if (sel_wr)
            begin
                channel_select_reg <= sel_wdata;
            end
            // Only the selected channel is visible
            channel_control_reg <= ctrl_flat[8*channel_select_reg +: 8];
            channel_data_reg    <= data_flat[16*channel_select_reg +: 16];
        end
    end

endmodule // cca_top

/* File: test/cca_tb_timebase.sv */
// Shared 16-bit timebase model facing the array.
// Assumes mclk and rst_n come from the bench; clear comes from the array.
`timescale 1ns/1ps
module cca_tb_timebase
(
    input  wire        mclk,     // System clock
    input  wire        rst_n,    // Reset, active low
    input  wire        run,      // Count enable
    input  wire        load,     // Load strobe from the bench
    input  wire [15:0] load_val, // Value to load
    input  wire        clear,    // Clear request from a channel event
    output reg  [15:0] count     // Timebase count
);
    // Clear beats load so a channel event always wins
    always @(posedge mclk or negedge rst_n)
        if (!rst_n)
            count <= 16'h0000;
        else if (clear)
            count <= 16'h0000;
        else if (load)
            count <= load_val;
        else if (run)
            count <= count + 16'h0001;
endmodule // cca_tb_timebase

/* File: test/cca_top_monitor.sv */
// Port-level checks on the compare/capture array.
// Assumes one clock domain; bound to every cca_top instance.
`timescale 1ns/1ps
module cca_top_monitor
#(
    parameter NCH = 4 // Channel count
)
(
    input wire           mclk,
    input wire           rst_n,
    input wire           sel_wr,
    input wire [1:0]     sel_wdata,
    input wire           flag_clr,
    input wire           array_irq_enable,
    input wire [15:0]    timebase_count,
    input wire           dac_enable,
    input wire           ext_mem_enable,
    input wire [1:0]     channel_select_reg,
    input wire [NCH-1:0] channel_flag_reg,
    input wire           irq,
    input wire           timebase_clear,
    input wire [NCH-1:0] channel_pin_out,
    input wire [NCH-1:0] channel_pin_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_reset_pins: assert property ($rose(rst_n) |->
        channel_pin_out == {NCH{1'b1}} && channel_pin_oe == '0) else $error("pins not idle");
    a_sel_load: assert property (sel_wr |=>
        channel_select_reg == $past(sel_wdata)) else $error("select not loaded");
    a_flag_sticky: assert property (!flag_clr |=>
        (channel_flag_reg & $past(channel_flag_reg)) == $past(channel_flag_reg))
        else $error("flag fell without clear");
    a_clear_with_flag: assert property (timebase_clear |->
        channel_flag_reg != '0) else $error("clear without flag");
    a_irq_needs_flag: assert property (irq |->
        channel_flag_reg != '0 && $past(array_irq_enable)) else $error("stray irq");
    a_extmem_quiet: assert property (ext_mem_enable && $past(ext_mem_enable) |->
        channel_pin_oe == '0) else $error("pin driven under memory bus");
    a_dac_quiet: assert property (dac_enable && $past(dac_enable) |->
        channel_pin_oe[NCH-1:2] == '0) else $error("pin driven under dac");
    a_pin_cause: assert property ($changed(channel_pin_out) |->
        channel_flag_reg != '0 || $past(timebase_count) == 16'h0000)
        else $error("pin moved without match");
endmodule // cca_top_monitor

bind cca_top cca_top_monitor #(.NCH(NCH)) u_mon (.mclk(mclk), .rst_n(rst_n),
    .sel_wr(sel_wr), .sel_wdata(sel_wdata), .flag_clr(flag_clr),
    .array_irq_enable(array_irq_enable), .timebase_count(timebase_count),
    .dac_enable(dac_enable), .ext_mem_enable(ext_mem_enable),
    .channel_select_reg(channel_select_reg), .channel_flag_reg(channel_flag_reg),
    .irq(irq), .timebase_clear(timebase_clear), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe));

/* File: test/cca_top_tb_top.sv */
// Self-checking bench for the compare/capture array.
// Assumes the timebase model stands beside the array; inputs move at negedge.
`timescale 1ns/1ps
module cca_top_tb_top;
    reg        mclk = 1'b0, rst_n, sel_wr, ctrl_wr, data_wr, flag_clr, run, load;
    reg        array_irq_enable, dac_enable, ext_mem_enable;
    reg [1:0]  sel_wdata, tmode;
    reg [7:0]  ctrl_wdata;
    reg [15:0] data_wdata, load_val;
    reg [3:0]  flag_clr_mask, pin, ev;
    reg [31:0] seed;
    wire [1:0] channel_select_reg;
    wire [7:0] channel_control_reg;
    wire [15:0] channel_data_reg, tb_count;
    wire [3:0] channel_flag_reg, channel_pin_out, channel_pin_oe;
    wire       irq, timebase_clear;
    integer    err_total, comparisons, i, k, e, hit, code, exp_pin;
    int        codes [7] = '{2, 3, 3, 1, 0, 4, 5}; // Compare action order
    int        cap_q [$] = '{0}; // Expected captures

    always #12.5 mclk = ~mclk;

    cca_tb_timebase u_tb (.mclk(mclk), .rst_n(rst_n), .run(run), .load(load),
        .load_val(load_val), .clear(timebase_clear), .count(tb_count));

    cca_top dut (.mclk(mclk), .rst_n(rst_n), .sel_wr(sel_wr), .sel_wdata(sel_wdata),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .flag_clr(flag_clr), .flag_clr_mask(flag_clr_mask),
        .array_irq_enable(array_irq_enable), .timebase_count(tb_count),
        .timebase_down(tmode[0]), .capture_reload_select(~tmode[1]), .timebase_count_mode(tmode),
        .timer0_ovf(ev[0]), .timer1_ovf(ev[1]), .comp_a_event(ev[2]), .comp_b_event(ev[3]),
        .channel_pin_in(pin), .dac_enable(dac_enable), .ext_mem_enable(ext_mem_enable),
        .channel_select_reg(channel_select_reg), .channel_control_reg(channel_control_reg),
        .channel_data_reg(channel_data_reg), .channel_flag_reg(channel_flag_reg),
        .irq(irq), .timebase_clear(timebase_clear), .channel_pin_out(channel_pin_out),
        .channel_pin_oe(channel_pin_oe));

    // Xorshift source, fixed start
    function [15:0] rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed[15:0];
    endfunction

    task chk(input string what, input [15:0] exp, input [15:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(negedge mclk);
    endtask

    // One strobe cycle: 0 select, 1 control, 2 data, 3 flag clear
    task wr(input integer which, input [15:0] v);
        @(negedge mclk);
        case (which)
            0: {sel_wr, sel_wdata} = {1'b1, v[1:0]};
            1: {ctrl_wr, ctrl_wdata} = {1'b1, v[7:0]};
            2: {data_wr, data_wdata} = {1'b1, v};
            default: {flag_clr, flag_clr_mask} = {1'b1, v[3:0]};
        endcase
        @(negedge mclk);
        {sel_wr, ctrl_wr, data_wr, flag_clr} = 4'h0;
    endtask

    task pulse(input [3:0] m);
        ev = m;
        cyc(1);
        ev = 4'h0;
    endtask

    task ld(input [15:0] v);
        {load, load_val} = {1'b1, v};
        cyc(1);
        load = 1'b0;
    endtask

    task finish_test;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        {sel_wr, ctrl_wr, data_wr, flag_clr, run, load, dac_enable, ext_mem_enable} = 8'h00;
        {sel_wdata, ctrl_wdata, data_wdata, load_val, flag_clr_mask, ev} = 50'h0;
        {tmode, pin, array_irq_enable, rst_n} = 8'h7e;
        {seed, err_total, comparisons, exp_pin} = {32'habe9, 32'h0, 32'h0, 32'h1};
        cyc(6);
        rst_n = 1'b1;
        cyc(1);
        chk("pin_out", 16'hf, channel_pin_out);
        chk("pin_oe", 16'h0, channel_pin_oe);
        // Control reaches only the selected channel; bits 6 and 5 do not stick
        wr(0, 2); wr(1, 16'h63); wr(0, 1); cyc(1);
        chk("ctrl_unsel", 16'h0, channel_control_reg);
        wr(0, 2); cyc(1);
        chk("ctrl_sel", 16'h3, channel_control_reg);
        // Compare actions on channel 0, timer stopped while rewriting
        wr(0, 0);
        for (i = 0; i < 7; i = i + 1)
        begin
            code = codes[i];
            wr(3, 4'hf);
            ld(16'h0);
            wr(2, 16'h8 + (rnd() & 16'h3f));
            wr(1, {i[0], 4'h3, code[2:0]});
            run = 1'b1;
            for (k = 0; k < 200 && timebase_clear !== 1'b1; k = k + 1)
                cyc(1);
            run = 1'b0;
            if (k == 200)
            begin
                err_total = err_total + 1;
                finish_test;
            end
            case (code)
                1, 5: exp_pin = 1;
                2, 4: exp_pin = 0;
                3: exp_pin = 1 - exp_pin;
                default: exp_pin = exp_pin;
            endcase
            chk("cmp_flag", 16'h1, channel_flag_reg[0]);
            chk("cmp_pin", exp_pin, channel_pin_out[0]);
            chk("cmp_oe", code > 0 && code < 6, channel_pin_oe[0]);
            chk("cmp_irq", i % 2, irq);
        end
        // Centre PWM
        wr(2, 16'h20);
        for (e = 0; e < 2; e = e + 1)
        begin
            tmode = {1'b1, e[0]}; wr(3, 4'hf); ld(16'h20); cyc(2);
            chk("pwm_ctr", e, channel_pin_out[0]);
            chk("dir_bit", e, channel_control_reg[6]);
        end
        wr(0, 2); wr(1, 16'h09);
        ext_mem_enable = 1'b1; cyc(2);
        chk("oe_extmem", 16'h0, channel_pin_oe);
        {ext_mem_enable, dac_enable} = 2'b01; cyc(2);
        chk("oe_dac", 16'h1, channel_pin_oe[2:0]);
        dac_enable = 1'b0;
        // Capture triggers on channel 1, decoys and a glitch first
        wr(0, 1);
        for (code = 0; code < 8; code = code + 1)
        begin
            pin[1] = 1'b1; wr(1, code); cyc(4); wr(3, 4'hf);
            pulse(code > 3 ? ~(4'h1 << (code - 4)) : 4'hf); cyc(4);
            chk("cap_decoy", 16'h0, channel_flag_reg[1]);
            pin[1] = 1'b0; cyc(1); pin[1] = 1'b1; cyc(5);
            chk("cap_glitch", 16'h0, channel_flag_reg[1]);
            for (e = 0; e < 2; e = e + 1)
            begin
                ld(rnd() | 16'h0100);
                if (code < 4)
                    pin[1] = ~pin[1];
                else if (e == 0)
                    pulse(4'h1 << (code - 4));
                cyc(5);
                hit = (code > 3) ? (e == 0) : (code == 3 || code == 1 + e);
                if (hit)
                    cap_q.push_back(load_val);
                chk("cap_flag", hit, channel_flag_reg[1]);
                chk("cap_data", cap_q[$], channel_data_reg);
                wr(3, 4'h2);
            end
        end
        finish_test;
    end
endmodule // cca_top_tb_top
